// ==== core/dcc_params_top.v ====
// Configuration layer of a two-channel digitizer controller.
// All options are fixed at elaboration; only the command streams and the external coefficient ports move at run time.
// Assumes synchronous inputs on ref_clk; serial engines and calibration math sit outside.
// Assumes the select pins reach the clock generator through tri-state pads with no pulls.
//
// Summary of operation
// - External enable picks ports, else static coefficients.
// - Static 18-bit gain coefficient per channel.
// - Static 18-bit offset coefficient per channel.
// - External mode ignores statics; core feeds ports.
// - Command path exists only when enabled.
// - Resolution derives from target module identifier.
// - Clock generator address 0x67, 0x68 or 0x69.
// - Reference select: 0 secondary, 1 primary.
// - Page select: 0 page 0, 1 page 1.
// - Frequency codes 0..6 map to fixed outputs.
// - Simulation option sends shortened command list.
// - Fall-back mode leaves select pins undriven.
// - Reference register codes 0x02 secondary, 0x03 primary.
`timescale 1ns/10ps
`include "dcc_consts.vh"

module dcc_params_top #(
   parameter [7:0] target_module_id = `DCC_ID_14BIT,
   parameter external_calibration_enable = 0,
   parameter external_command_path_enable = 0,
   parameter [17:0] ch1_static_gain_coef = 18'h10000,
   parameter [17:0] ch1_static_offset_coef = 18'h00000,
   parameter [17:0] ch2_static_gain_coef = 18'h10000,
   parameter [17:0] ch2_static_offset_coef = 18'h00000,
   parameter short_sim_setup_enable = 0,
   parameter [7:0] short_sim_command_count = 8'h02,
   parameter [6:0] clockgen_serial_address = `DCC_CG_ADDR_FALLBACK,
   parameter reference_input_select = 0,
   parameter config_page_select = 0,
   parameter [2:0] sample_frequency_select = `DCC_FREQ_122M88
) (
   // Clock, reset and enable.
   input wire ref_clk,
   input wire arst_n,
   input wire clk_en,
   // External calibration coefficients from a higher-level core.
   input wire [17:0] ext_ch1_gain_coef,
   input wire [17:0] ext_ch1_offset_coef,
   input wire [17:0] ext_ch2_gain_coef,
   input wire [17:0] ext_ch2_offset_coef,
   // Coefficients in use, towards the calibration unit.
   output reg [17:0] ch1_gain_coef_r,
   output reg [17:0] ch1_offset_coef_r,
   output reg [17:0] ch2_gain_coef_r,
   output reg [17:0] ch2_offset_coef_r,
   // Converter information.
   output reg [4:0] converter_resolution_r,
   // Clock generator setup control and status.
   input wire cg_setup_start,
   output reg cg_setup_done_r,
   output reg cg_cmd_valid_r,
   output reg [31:0] cg_cmd_word_r,
   input wire cg_cmd_ready,
   // Clock generator select pins, each as output and output enable.
   output reg reference_select_pin_o_r,
   output reg reference_select_pin_oe_r,
   output reg page_select_pin_o_r,
   output reg page_select_pin_oe_r,
   // Built-in converter setup status.
   input wire converter_init_done,
   // Upper-layer command path from a processor.
   input wire up_cmd_valid,
   input wire [31:0] up_cmd_data,
   output reg up_cmd_ready_r,
   // Command path towards the converter serial port.
   output reg conv_cmd_valid_r,
   output reg [31:0] conv_cmd_data_r,
   input wire conv_cmd_ready,
   // Read data from the converter serial port back to the processor.
   input wire conv_rsp_valid,
   input wire [31:0] conv_rsp_data,
   output reg up_rsp_valid_r,
   output reg [31:0] up_rsp_data_r,
   // Status of the command path.
   output reg cmd_path_open_r
);

   // Resolution follows the module identifier; unknown identifiers fall back to 14 bits.
   // A new module identifier needs an entry here and in the constants header together.
   function [4:0] res_of_id;
      input [7:0] id;
      begin
         case (id)
            `DCC_ID_12BIT: res_of_id = `DCC_RES_12BIT;
            default: res_of_id = `DCC_RES_14BIT;
         endcase
      end
   endfunction

   // Selects one coefficient according to the calibration source.
   // The choice is constant, so synthesis keeps only the source in use.
   function [17:0] coef_sel;
      input [17:0] ext_val;
      input [17:0] static_val;
      begin
         coef_sel = external_calibration_enable ? ext_val : static_val;
      end
   endfunction

   // Option checks; every one of them is an elaboration-time constant.
   localparam [4:0] RESOLUTION = res_of_id(target_module_id);
   localparam FREQ_OK = (sample_frequency_select <= `DCC_FREQ_MAX);
   localparam ADDR_OK = (clockgen_serial_address == `DCC_CG_ADDR_FALLBACK) ||
                        (clockgen_serial_address == `DCC_CG_ADDR_DEFAULT) ||
                        (clockgen_serial_address == `DCC_CG_ADDR_ALT);

   // Plain Verilog has no elaboration-time error, so a frequency code above 6 is
   // replaced by code 0. The generator then runs from the crystal at its first
   // listed rate instead of from a table entry that does not exist; a mistyped
   // code shows up as a wrong rate, never as a missing clock.
   localparam [2:0] FREQ_CODE = FREQ_OK ? sample_frequency_select : `DCC_FREQ_122M88;

   // An address outside the three legal ones is replaced by the fall-back address.
   // That choice also releases both select pins, the one state in which a wrong
   // option cannot fight the levels the generator sees on its pins.
   localparam [6:0] CG_ADDR = ADDR_OK ? clockgen_serial_address : `DCC_CG_ADDR_FALLBACK;
   localparam FALLBACK = (CG_ADDR == `DCC_CG_ADDR_FALLBACK);

   // Value and enable of one select pin. Both pins go through it, so they can
   // never disagree about fall-back mode.
   function [1:0] pin_drive;
      input sel_high;
      begin
         pin_drive = {sel_high, !FALLBACK};
      end
   endfunction

   // Coefficients are registered so the calibration unit sees stable values;
   // in external mode the statics never reach the outputs.
   // The register also cuts the timing path from the higher-level core, at the
   // price of one cycle before a new external value takes effect.
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ch1_gain_coef_r <= 18'h00000;
         ch1_offset_coef_r <= 18'h00000;
         ch2_gain_coef_r <= 18'h00000;
         ch2_offset_coef_r <= 18'h00000;
      end else if (clk_en) begin
         ch1_gain_coef_r <= coef_sel(ext_ch1_gain_coef, ch1_static_gain_coef);
         ch1_offset_coef_r <= coef_sel(ext_ch1_offset_coef, ch1_static_offset_coef);
         ch2_gain_coef_r <= coef_sel(ext_ch2_gain_coef, ch2_static_gain_coef);
         ch2_offset_coef_r <= coef_sel(ext_ch2_offset_coef, ch2_static_offset_coef);
      end
   end

   // Resolution is a constant but still leaves through a flip-flop.
   // Downstream logic sizes itself from this port, so it is defined in one place.
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         converter_resolution_r <= 5'h00;
      end else if (clk_en) begin
         converter_resolution_r <= RESOLUTION;
      end
   end

   // Decoded pin drive, value in bit 1 and enable in bit 0; the flops below
   // only add the output register.
   wire [1:0] ref_pin_drive;
   wire [1:0] page_pin_drive;
   assign ref_pin_drive = pin_drive(reference_input_select != 0);
   assign page_pin_drive = pin_drive(config_page_select != 0);

   // Select pins: released in fall-back mode so the generator keeps its serial
   // port open and ignores its stored pages; pull resistors would defeat this.
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         reference_select_pin_o_r <= 1'b0;
         reference_select_pin_oe_r <= 1'b0;
         page_select_pin_o_r <= 1'b0;
         page_select_pin_oe_r <= 1'b0;
      end else if (clk_en) begin
         reference_select_pin_o_r <= ref_pin_drive[1];
         reference_select_pin_oe_r <= ref_pin_drive[0];
         page_select_pin_o_r <= page_pin_drive[1];
         page_select_pin_oe_r <= page_pin_drive[0];
      end
   end

   // Raw sequencer outputs, one cycle ahead of the ports of this module.
   wire seq_done;
   wire seq_valid;
   wire [31:0] seq_word;

   // Clock generator command list, trimmed for simulation when asked.
   // The list is built from the checked address and code, never the raw address or frequency options.
   // Start is a level: hold it until done, then drop it to rearm the sequencer.
   dcc_cg_seq #(
      .CG_ADDR(CG_ADDR),
      .REF_SEL(reference_input_select),
      .FREQ_SEL(FREQ_CODE),
      .SHORT_SIM(short_sim_setup_enable),
      .SHORT_COUNT(short_sim_command_count)
   ) u_seq (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .start(cg_setup_start),
      .done_r(seq_done),
      .cmd_valid_r(seq_valid),
      .cmd_word_r(seq_word),
      .cmd_ready(cg_cmd_ready)
   );

   // Sequencer outputs are already flopped; these copies keep the outputs
   // of this module flop-driven and cost one cycle of latency.
   // The two idle cycles after each handshake also leave the serial engine time
   // to latch the word before the next one appears.
   reg fwd_pending_r;
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cg_cmd_valid_r <= 1'b0;
         cg_cmd_word_r <= 32'h0000_0000;
         cg_setup_done_r <= 1'b0;
         fwd_pending_r <= 1'b0;
      end else if (clk_en) begin
         cg_setup_done_r <= seq_done;
         cg_cmd_word_r <= seq_word;
         // Drop valid the cycle after a handshake so one word is never sent twice.
         if (cg_cmd_valid_r && cg_cmd_ready) begin
            cg_cmd_valid_r <= 1'b0;
            fwd_pending_r <= 1'b1;
         end else if (fwd_pending_r) begin
            cg_cmd_valid_r <= 1'b0;
            fwd_pending_r <= 1'b0;
         end else begin
            cg_cmd_valid_r <= seq_valid;
         end
      end
   end

   // The path opens only after the built-in setup is complete, so the processor
   // cannot race the initial converter configuration.
   // Both dones are levels, so the path stays open until a new setup starts.
   wire path_allowed;
   assign path_allowed = (external_command_path_enable != 0) &&
                         converter_init_done && cg_setup_done_r;

   // Next values of the command path registers.
   reg path_open_nxt;
   reg up_ready_nxt;
   reg conv_valid_nxt;
   reg [31:0] conv_data_nxt;

   // One-entry forwarding stage: ready is withheld while a word waits downstream.
   // Taking a new word and draining the old one in one cycle cannot happen, since
   // ready is registered low in every cycle in which a word is still waiting.
   always @* begin
      path_open_nxt = path_allowed;
      conv_valid_nxt = conv_cmd_valid_r;
      conv_data_nxt = conv_cmd_data_r;
      if (conv_cmd_valid_r && conv_cmd_ready) begin
         conv_valid_nxt = 1'b0;
      end
      if (up_cmd_valid && up_cmd_ready_r) begin
         conv_valid_nxt = 1'b1;
         conv_data_nxt = up_cmd_data;
      end
      up_ready_nxt = path_allowed && !conv_valid_nxt;
   end

   // Command path registers; they stay at reset values when the path is disabled.
   // A disabled path therefore shows a closed, idle interface, never stale values.
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cmd_path_open_r <= 1'b0;
         up_cmd_ready_r <= 1'b0;
         conv_cmd_valid_r <= 1'b0;
         conv_cmd_data_r <= 32'h0000_0000;
      end else if (clk_en) begin
         cmd_path_open_r <= path_open_nxt;
         up_cmd_ready_r <= up_ready_nxt;
         conv_cmd_valid_r <= conv_valid_nxt;
         conv_cmd_data_r <= conv_data_nxt;
      end
   end

   // Responses pass back as one-cycle pulses; with the path disabled nothing returns.
   // Data is held between pulses so a slow reader may still pick it up; only the
   // valid flag is a pulse.
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         up_rsp_valid_r <= 1'b0;
         up_rsp_data_r <= 32'h0000_0000;
      end else if (clk_en) begin
         up_rsp_valid_r <= conv_rsp_valid && (external_command_path_enable != 0);
         if (conv_rsp_valid && (external_command_path_enable != 0)) begin
            up_rsp_data_r <= conv_rsp_data;
         end
      end
   end

endmodule // dcc_params_top

// ==== pkg/dcc_consts.vh ====
// Constants shared by the digitizer controller configuration layer.
// Assumes it is included by bare name from the design files under core/.
`ifndef DCC_CONSTS_VH
`define DCC_CONSTS_VH

// Calibration coefficient width per channel.
`define DCC_COEF_W 18
// Converter command word width on the upper-layer path.
`define DCC_CMD_W 32

// Clock generator 7-bit serial addresses.
`define DCC_CG_ADDR_FALLBACK 7'h67
`define DCC_CG_ADDR_DEFAULT 7'h68
`define DCC_CG_ADDR_ALT 7'h69

// Reference software-select field: register index and its two codes.
`define DCC_CG_REFERENCE_SELECT_PIN_REG 8'h02
`define DCC_CG_REFERENCE_SELECT_PIN_SECONDARY 8'h02
`define DCC_CG_REFERENCE_SELECT_PIN_PRIMARY 8'h03

// Frequency selection codes, 0 to 6.
`define DCC_FREQ_122M88 3'h0
`define DCC_FREQ_50M 3'h1
`define DCC_FREQ_80M 3'h2
`define DCC_FREQ_100M 3'h3
`define DCC_FREQ_110M 3'h4
`define DCC_FREQ_120M 3'h5
`define DCC_FREQ_125M 3'h6
`define DCC_FREQ_MAX 6

// Length of the full clock generator setup, in commands.
`define DCC_CG_CMD_TOTAL 8'h10

// Target module identifiers and the resolutions they imply.
`define DCC_ID_14BIT 8'h01
`define DCC_ID_12BIT 8'h02
`define DCC_RES_14BIT 5'h0e
`define DCC_RES_12BIT 5'h0c

`endif

// ==== core/dcc_cg_seq.v ====
// Clock generator setup sequencer: emits the serial command list.
// Assumes a serial engine outside takes one command per valid/ready handshake.
`timescale 1ns/10ps
`include "dcc_consts.vh"

module dcc_cg_seq #(
   parameter [6:0] CG_ADDR = `DCC_CG_ADDR_FALLBACK,
   parameter REF_SEL = 0,
   parameter [2:0] FREQ_SEL = `DCC_FREQ_122M88,
   parameter SHORT_SIM = 0,
   parameter [7:0] SHORT_COUNT = 8'h02
) (
   // Clock, reset and enable.
   input wire ref_clk,
   input wire arst_n,
   input wire clk_en,
   // Sequence control.
   input wire start,
   output reg done_r,
   // Command stream towards the serial engine.
   output reg cmd_valid_r,
   output reg [31:0] cmd_word_r,
   input wire cmd_ready
);

   // The shortened list only trims the tail; the reference write stays first.
   localparam [7:0] LAST_IDX = SHORT_SIM ? (SHORT_COUNT - 8'h01) : (`DCC_CG_CMD_TOTAL - 8'h01);

   // Command word: address, register index, data.
   function [31:0] cmd_word;
      input [7:0] idx;
      reg [7:0] data;
      begin
         data = {FREQ_SEL, idx[4:0]};
         if (idx == 8'h00) begin
            // The reference is forced by register so the pin level never matters.
            data = REF_SEL ? `DCC_CG_REFERENCE_SELECT_PIN_PRIMARY : `DCC_CG_REFERENCE_SELECT_PIN_SECONDARY;
            cmd_word = {1'b0, CG_ADDR, 8'h00, `DCC_CG_REFERENCE_SELECT_PIN_REG, data};
         end else begin
            cmd_word = {1'b0, CG_ADDR, 8'h00, idx, data};
         end
      end
   endfunction

   localparam ST_IDLE = 2'h0;
   localparam ST_SEND = 2'h1;
   localparam ST_DONE = 2'h2;

   reg [1:0] state_r;
   reg [7:0] idx_r;

   // Walk the list once per start; a new start after done reruns it.
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= ST_IDLE;
         idx_r <= 8'h00;
         done_r <= 1'b0;
         cmd_valid_r <= 1'b0;
         cmd_word_r <= 32'h0000_0000;
      end else if (clk_en) begin
         case (state_r)
            ST_IDLE: begin
               if (start) begin
                  idx_r <= 8'h00;
                  done_r <= 1'b0;
                  cmd_valid_r <= 1'b1;
                  cmd_word_r <= cmd_word(8'h00);
                  state_r <= ST_SEND;
               end
            end
            ST_SEND: begin
               if (cmd_ready) begin
                  if (idx_r == LAST_IDX) begin
                     cmd_valid_r <= 1'b0;
                     done_r <= 1'b1;
                     state_r <= ST_DONE;
                  end else begin
                     idx_r <= idx_r + 8'h01;
                     cmd_word_r <= cmd_word(idx_r + 8'h01);
                  end
               end
            end
            ST_DONE: begin
               if (!start) begin
                  state_r <= ST_IDLE;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // dcc_cg_seq

// ==== test/dcc_params_chk.sv ====
// Concurrent checks on the digitizer configuration layer ports.
// Assumes it is bound to dcc_params_top with its options handed on.
`timescale 1ns/10ps
module dcc_params_chk #(
   parameter EXT = 0,
   parameter [17:0] GAIN1 = 18'h0,
   parameter [7:0] RID = 8'h01,
   parameter [6:0] ADDR = 7'h67,
   parameter REF = 0,
   parameter PAGE = 0
) (
   // Clock, reset and enable.
   input wire ref_clk,
   input wire arst_n,
   input wire clk_en,
   // Coefficient and resolution.
   input wire [17:0] ext_ch1_gain_coef,
   input wire [17:0] ch1_gain_coef_r,
   input wire [4:0] converter_resolution_r,
   // Clock generator stream and pins.
   input wire cg_cmd_valid_r,
   input wire [31:0] cg_cmd_word_r,
   input wire cg_cmd_ready,
   input wire reference_select_pin_o_r,
   input wire reference_select_pin_oe_r,
   input wire page_select_pin_o_r,
   input wire page_select_pin_oe_r,
   // Upper-layer command path.
   input wire up_cmd_valid,
   input wire [31:0] up_cmd_data,
   input wire up_cmd_ready_r,
   input wire conv_cmd_valid_r,
   input wire [31:0] conv_cmd_data_r
);
   // Fall-back mode follows from the address alone, so the pins must float there.
   localparam FB = (ADDR == 7'h67);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   gain_select_a: assert property ($past(arst_n) && $past(clk_en) |->
      ch1_gain_coef_r == (EXT ? $past(ext_ch1_gain_coef) : GAIN1)) else $error("bad gain");
   res_from_id_a: assert property ($past(arst_n) && $past(clk_en) |->
      converter_resolution_r == (RID == 8'h02 ? 5'h0c : 5'h0e)) else $error("bad resolution");
   ref_pin_a: assert property ($past(arst_n) && $past(clk_en) |->
      reference_select_pin_oe_r == !FB && (FB || reference_select_pin_o_r == (REF != 0)))
      else $error("bad reference pin");
   page_pin_a: assert property ($past(arst_n) && $past(clk_en) |->
      page_select_pin_oe_r == !FB && (FB || page_select_pin_o_r == (PAGE != 0)))
      else $error("bad page pin");
   cmd_addr_a: assert property (cg_cmd_valid_r |->
      cg_cmd_word_r[31:16] == {1'b0, ADDR, 8'h00}) else $error("bad address");
   cmd_hold_a: assert property (cg_cmd_valid_r && !cg_cmd_ready |=>
      cg_cmd_valid_r && $stable(cg_cmd_word_r)) else $error("command dropped");
   cmd_gap_a: assert property (cg_cmd_valid_r && cg_cmd_ready && clk_en |=>
      !cg_cmd_valid_r) else $error("no gap after command");
   up_fwd_a: assert property (up_cmd_valid && up_cmd_ready_r && clk_en |=>
      conv_cmd_valid_r && !up_cmd_ready_r && conv_cmd_data_r == $past(up_cmd_data))
      else $error("command not forwarded");
endmodule // dcc_params_chk

bind dcc_params_top dcc_params_chk #(.EXT(external_calibration_enable),
   .GAIN1(ch1_static_gain_coef), .RID(target_module_id), .ADDR(clockgen_serial_address),
   .REF(reference_input_select), .PAGE(config_page_select)) u_dcc_params_chk (
   .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .ext_ch1_gain_coef(ext_ch1_gain_coef),
   .ch1_gain_coef_r(ch1_gain_coef_r), .converter_resolution_r(converter_resolution_r),
   .cg_cmd_valid_r(cg_cmd_valid_r), .cg_cmd_word_r(cg_cmd_word_r), .cg_cmd_ready(cg_cmd_ready),
   .reference_select_pin_o_r(reference_select_pin_o_r),
   .reference_select_pin_oe_r(reference_select_pin_oe_r),
   .page_select_pin_o_r(page_select_pin_o_r), .page_select_pin_oe_r(page_select_pin_oe_r),
   .up_cmd_valid(up_cmd_valid), .up_cmd_data(up_cmd_data), .up_cmd_ready_r(up_cmd_ready_r),
   .conv_cmd_valid_r(conv_cmd_valid_r), .conv_cmd_data_r(conv_cmd_data_r));

// ==== test/dcc_cg_engine_model.sv ====
// Far-side model: clock generator serial engine and converter serial port.
// Assumes outputs change at the falling edge; the design samples at the rising edge.
`timescale 1ns/10ps
module dcc_cg_engine_model (
   // Clock, reset and pacing.
   input wire ref_clk,
   input wire arst_n,
   input wire [3:0] slow,
   // Clock generator command stream.
   input wire cg_cmd_valid_r,
   input wire [31:0] cg_cmd_word_r,
   output logic cg_cmd_ready,
   // Converter serial port.
   input wire conv_cmd_valid_r,
   input wire [31:0] conv_cmd_data_r,
   output logic conv_cmd_ready,
   output logic conv_rsp_valid,
   output logic [31:0] conv_rsp_data
);
   logic [31:0] words [0:31];
   logic [31:0] held;
   int n = 0;
   int wait_n;

   // Every word taken is logged so the bench can judge the whole setup list.
   always @(posedge ref_clk) begin
      if (cg_cmd_valid_r && cg_cmd_ready) begin
         words[n[4:0]] <= cg_cmd_word_r;
         n <= n + 1;
      end
   end

   // Generator ready comes after slow idle cycles, converter ready at once; idle read data toggles so it is never trusted.
   always @(negedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         {cg_cmd_ready, conv_cmd_ready, conv_rsp_valid} <= 3'h0;
         conv_rsp_data <= 32'h0;
         wait_n <= 0;
      end else begin
         cg_cmd_ready <= cg_cmd_valid_r && !cg_cmd_ready && wait_n >= slow;
         wait_n <= (cg_cmd_valid_r && !cg_cmd_ready) ? wait_n + 1 : 0;
         conv_cmd_ready <= conv_cmd_valid_r && !conv_cmd_ready;
         if (conv_cmd_valid_r && !conv_cmd_ready) held <= conv_cmd_data_r;
         conv_rsp_valid <= conv_cmd_ready;
         conv_rsp_data <= conv_cmd_ready ? held ^ 32'h5a5a5a5a : ~conv_rsp_data;
      end
   end
endmodule // dcc_cg_engine_model

// ==== test/tb_top.sv ====
// Self-checking bench for the digitizer configuration layer.
// Assumes the design, checker and far-side model are compiled before it.
`timescale 1ns/10ps
module tb_top;
   logic ref_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, start = 1'b0;
   logic init_done = 1'b0, up_valid = 1'b0;
   logic [31:0] up_data = 32'h0;
   logic [17:0] eg1 = 18'h0, eo1 = 18'h0, eg2 = 18'h0, eo2 = 18'h0;
   logic [3:0] slow = 4'h0;
   wire [17:0] g1, o1, g2, o2;
   wire [4:0] res;
   wire done, cg_valid, cg_ready, ref_o, ref_oe, pg_o, pg_oe, up_ready;
   wire cv_valid, cv_ready, rsp_valid, ursp_valid, path_open;
   wire [31:0] cg_word, cv_data, rsp_data, ursp_data;
   int bad_count = 0;
   int checks = 0;

   // Five options are overridden; the rest keep their defaults and are judged as such.
   dcc_params_top #(.external_command_path_enable(1), .short_sim_setup_enable(1),
      .clockgen_serial_address(7'h68), .reference_input_select(1),
      .sample_frequency_select(3'h5)) u_dcc_params_top (
      .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .ext_ch1_gain_coef(eg1),
      .ext_ch1_offset_coef(eo1), .ext_ch2_gain_coef(eg2), .ext_ch2_offset_coef(eo2),
      .ch1_gain_coef_r(g1), .ch1_offset_coef_r(o1), .ch2_gain_coef_r(g2),
      .ch2_offset_coef_r(o2), .converter_resolution_r(res), .cg_setup_start(start),
      .cg_setup_done_r(done), .cg_cmd_valid_r(cg_valid), .cg_cmd_word_r(cg_word),
      .cg_cmd_ready(cg_ready), .reference_select_pin_o_r(ref_o),
      .reference_select_pin_oe_r(ref_oe), .page_select_pin_o_r(pg_o),
      .page_select_pin_oe_r(pg_oe), .converter_init_done(init_done), .up_cmd_valid(up_valid),
      .up_cmd_data(up_data), .up_cmd_ready_r(up_ready), .conv_cmd_valid_r(cv_valid),
      .conv_cmd_data_r(cv_data), .conv_cmd_ready(cv_ready), .conv_rsp_valid(rsp_valid),
      .conv_rsp_data(rsp_data), .up_rsp_valid_r(ursp_valid), .up_rsp_data_r(ursp_data),
      .cmd_path_open_r(path_open));

   dcc_cg_engine_model u_dcc_cg_engine_model (.ref_clk(ref_clk), .arst_n(arst_n),
      .slow(slow), .cg_cmd_valid_r(cg_valid), .cg_cmd_word_r(cg_word), .cg_cmd_ready(cg_ready),
      .conv_cmd_valid_r(cv_valid), .conv_cmd_data_r(cv_data), .conv_cmd_ready(cv_ready),
      .conv_rsp_valid(rsp_valid), .conv_rsp_data(rsp_data));

   // One shared compare keeps every report in the same form.
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // External values must not leak through, even with the clock enable toggled.
   task automatic t_coefs;
      for (int k = 0; k < 3; k++) begin
         clk_en = (k != 1);
         {eg1, eo1, eg2, eo2} = {4{18'h15555 ^ k[17:0]}};
         repeat (2) @(negedge ref_clk);
         cmp(g1, 18'h10000);
         cmp(o1, 18'h00000);
         cmp(g2, 18'h10000);
         cmp(o2, 18'h00000);
         cmp(res, 5'h0e);
      end
      clk_en = 1'b1;
   endtask

   // A full short setup run; s sets how long the engine stalls each command.
   task automatic t_setup(input logic [3:0] s);
      int base;
      logic [31:0] exp;
      slow = s;
      base = u_dcc_cg_engine_model.n;
      start = 1'b1;
      repeat (3) @(negedge ref_clk);
      for (int i = 0; i < 300 && done !== 1'b1; i++) @(negedge ref_clk);
      cmp(done, 1'b1);
      cmp(u_dcc_cg_engine_model.n - base, 2);
      cmp(up_ready, 1'b0);
      for (int k = 0; k < 2; k++) begin
         exp = (k == 0) ? 32'h68000203 : {16'h6800, k[7:0], 3'h5, k[4:0]};
         cmp(u_dcc_cg_engine_model.words[(base + k) % 32], exp);
      end
      start = 1'b0;
      repeat (3) @(negedge ref_clk);
   endtask

   // Two commands in turn through the processor path, each answered before the next is sent.
   task automatic t_path;
      logic [31:0] d;
      init_done = 1'b1;
      for (int j = 0; j < 2; j++) begin
         d = 32'hc0de0010 + j;
         for (int i = 0; i < 50 && up_ready !== 1'b1; i++) @(negedge ref_clk);
         cmp(path_open, 1'b1);
         up_valid = 1'b1;
         up_data = d;
         @(negedge ref_clk);
         up_valid = 1'b0;
         cmp({cv_valid, up_ready, cv_data}, {2'b10, d});
         for (int i = 0; i < 20 && ursp_valid !== 1'b1; i++) @(negedge ref_clk);
         cmp(ursp_valid, 1'b1);
         cmp(ursp_data, d ^ 32'h5a5a5a5a);
      end
   endtask

   task close_out;
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Free-running clock at 250 MHz.
   always #2 ref_clk = ~ref_clk;

   // Watchdog: the tests need well under a tenth of this span.
   initial begin
      #40000;
      bad_count++;
      close_out;
   end

   // Main sequence; reset is checked while still held.
   initial begin
      repeat (6) @(negedge ref_clk);
      cmp({ref_oe, pg_oe, g1}, 20'h0);
      arst_n = 1'b1;
      t_coefs;
      cmp({ref_o, ref_oe, pg_o, pg_oe}, 4'hd);
      t_setup(4'h3);
      t_setup(4'h0);
      t_path;
      close_out;
   end
endmodule // tb_top
